/* File: core/rcr_pkg.sv */
// constants and types for the rail control register bank
//
// Contract
// - converter uses sleep code when field 11, pin low
// - sleep pin per rail fixed at build time
// - converter bits 3:2 reset 11, host writes 11
// - converter mode bit: 0 automatic, 1 forced PWM
// - converter disable bit 0 forces converter off
// - first linear uses sleep code when field 11
// - linear bits 3:1 reset 110, host writes 110
// - first linear disable bit 0 forces it off
// - second linear uses sleep code when field 11
// - second linear disable bit 0 forces it off
package rcr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CONV_F_OFFSET = 8'h27;
    localparam logic [7:0] LIN_B_OFFSET  = 8'h28;
    localparam logic [7:0] LIN_C_OFFSET  = 8'h29;

    // ------------------------------------------------------------
    // field layout and encodings
    // ------------------------------------------------------------
    localparam int         SLEEP_MSB    = 5;
    localparam int         SLEEP_LSB    = 4;
    localparam int         MODE_BIT     = 1;
    localparam int         DISABLE_BIT  = 0;
    localparam logic [1:0] SLEEP_ACTIVE = 2'h3;
    localparam logic [1:0] SLEEP_OFF    = 2'h0;
    localparam logic [7:0] WRITE_MASK   = 8'h3f;
    localparam logic [7:0] UNMAPPED_RD  = 8'h00;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [1:0] CONV_RSVD_RESET  = 2'h3;
    localparam logic [2:0] LIN_RSVD_RESET   = 3'h6;
    localparam logic [7:0] CONV_FACTORY_DEF = 8'h0d;
    localparam logic [7:0] LIN_FACTORY_DEF  = 8'h0d;
    localparam logic [7:0] SYNC_RESET       = 8'h03;
    localparam logic [7:0] CODE_RESET       = 8'h00;
    localparam int         NUM_EN_PINS      = 6;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic
    {
        SLEEP_PIN_ONE = 1'b0,
        SLEEP_PIN_TWO = 1'b1
    } rcr_sleep_pin_t;

    typedef struct packed
    {
        logic [7:0] code;
        logic       on;
        logic       forcedPwm;
    } rcr_rail_out_t;

    typedef struct packed
    {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } rcr_reg_req_t;

endpackage

/* File: core/rcr_rail.sv */
// per-rail voltage code selection, enable gating and mode output
`timescale 1ns/10ps
`default_nettype none

module rcr_rail
#(
    parameter bit         HAS_MODE = 1'b0,
    parameter logic [5:0] EN_MASK  = 6'h01
)
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstN,
    // control register and pins
    input  wire logic [7:0]             ctrl,
    input  wire logic                   sleepLvl,
    input  wire logic [5:0]             enPins,
    // voltage codes
    input  wire logic [7:0]             normalCode,
    input  wire logic [7:0]             sleepCode,
    // rail outputs
    output var  rcr_pkg::rcr_rail_out_t railOut
);

    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    // reserved field values fall back to the normal code
    wire logic       sleepArmed;
    wire logic       useSleep;
    wire logic       pinEnable;
    wire logic       permitted;
    wire logic [7:0] codeNext;
    wire logic       onNext;
    wire logic       pwmNext;

    assign sleepArmed = ctrl[rcr_pkg::SLEEP_MSB:rcr_pkg::SLEEP_LSB]
                        == rcr_pkg::SLEEP_ACTIVE;
    assign useSleep   = sleepArmed && !sleepLvl;
    assign codeNext   = useSleep ? sleepCode : normalCode;
    assign pinEnable  = |(enPins & EN_MASK);
    assign permitted  = ctrl[rcr_pkg::DISABLE_BIT];
    assign onNext     = permitted && pinEnable;
    assign pwmNext    = HAS_MODE && ctrl[rcr_pkg::MODE_BIT];

    always_ff @(posedge clk)
    begin
        if (!rstN)
        begin
            railOut <= '{code: rcr_pkg::CODE_RESET, on: 1'b0, forcedPwm: 1'b0};
        end
        else
        begin
            railOut <= '{code: codeNext, on: onNext, forcedPwm: pwmNext};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstN);

    // the release edge still loads reset values, so attempts are gated
    // by the sampled reset as well as by the disable
    a_sleep_code_used: assert property (
        (rstN && ctrl[5:4] == 2'h3 && !sleepLvl)
        |=> railOut.code == $past(sleepCode))
        else $error("sleep code not applied");
    a_normal_code_used: assert property (
        (rstN && (ctrl[5:4] != 2'h3 || sleepLvl))
        |=> railOut.code == $past(normalCode))
        else $error("normal code not applied");
    a_disable_forces_off: assert property (
        !ctrl[0] |=> !railOut.on)
        else $error("rail on while disabled");
    a_pins_enable_rail: assert property (
        (rstN && ctrl[0] && |(enPins & EN_MASK)) |=> railOut.on)
        else $error("permitted rail not enabled by pin");
    a_mode_follows_bit: assert property (
        rstN |=> railOut.forcedPwm == (HAS_MODE && $past(ctrl[1])))
        else $error("operating mode mismatch");

endmodule

`default_nettype wire

/* File: core/rcr_bank.sv */
// rail control register bank: converter f, linear b, linear c
`timescale 1ns/10ps
`default_nettype none

module rcr_bank
#(
    // build-time factory configuration
    parameter logic [7:0]              CONV_FACTORY  = rcr_pkg::CONV_FACTORY_DEF,
    parameter logic [7:0]              LINB_FACTORY  = rcr_pkg::LIN_FACTORY_DEF,
    parameter logic [7:0]              LINC_FACTORY  = rcr_pkg::LIN_FACTORY_DEF,
    parameter rcr_pkg::rcr_sleep_pin_t CONV_SLEEP_PIN = rcr_pkg::SLEEP_PIN_ONE,
    parameter rcr_pkg::rcr_sleep_pin_t LINB_SLEEP_PIN = rcr_pkg::SLEEP_PIN_ONE,
    parameter rcr_pkg::rcr_sleep_pin_t LINC_SLEEP_PIN = rcr_pkg::SLEEP_PIN_TWO,
    parameter logic [5:0]              CONV_EN_MASK  = 6'h01,
    parameter logic [5:0]              LINB_EN_MASK  = 6'h02,
    parameter logic [5:0]              LINC_EN_MASK  = 6'h04
)
(
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    // register access from the serial interface core
    input  wire rcr_pkg::rcr_reg_req_t  regReq,
    output var  logic [7:0]             regRdData,
    // device pins, asynchronous
    input  wire logic                   sleepPinOne_n,
    input  wire logic                   sleepPinTwo_n,
    input  wire logic [5:0]             enableControlPins,
    // voltage codes from the voltage registers
    input  wire logic [7:0]             convFVoltageCode,
    input  wire logic [7:0]             convFSleepVoltageCode,
    input  wire logic [7:0]             linBVoltageCode,
    input  wire logic [7:0]             linBSleepVoltageCode,
    input  wire logic [7:0]             linCVoltageCode,
    input  wire logic [7:0]             linCSleepVoltageCode,
    // rail controls
    output var  rcr_pkg::rcr_rail_out_t convFOut,
    output var  rcr_pkg::rcr_rail_out_t linBOut,
    output var  rcr_pkg::rcr_rail_out_t linCOut
);

    // ------------------------------------------------------------
    // reset images
    // ------------------------------------------------------------
    // reserved bits are forced to their fixed value whatever the
    // factory image holds, and bits 7:6 are always zero
    localparam logic [7:0] CONV_RESET =
        {2'h0, CONV_FACTORY[5:4], rcr_pkg::CONV_RSVD_RESET, CONV_FACTORY[1:0]};
    localparam logic [7:0] LINB_RESET =
        {2'h0, LINB_FACTORY[5:4], rcr_pkg::LIN_RSVD_RESET, LINB_FACTORY[0]};
    localparam logic [7:0] LINC_RESET =
        {2'h0, LINC_FACTORY[5:4], rcr_pkg::LIN_RSVD_RESET, LINC_FACTORY[0]};

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // bits 7:2 enable pins, bit 1 sleep pin two, bit 0 sleep pin one
    logic [7:0] syncStage1_reg;
    logic [7:0] syncStage2_reg;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            syncStage1_reg <= rcr_pkg::SYNC_RESET;
            syncStage2_reg <= rcr_pkg::SYNC_RESET;
        end
        else
        begin
            syncStage1_reg <= {enableControlPins, sleepPinTwo_n, sleepPinOne_n};
            syncStage2_reg <= syncStage1_reg;
        end
    end

    wire logic [5:0] enPinsSync;
    wire logic       convSleepLvl;
    wire logic       linBSleepLvl;
    wire logic       linCSleepLvl;

    assign enPinsSync   = syncStage2_reg[7:2];
    // pin routing is a build-time choice, software cannot move it
    assign convSleepLvl = syncStage2_reg[CONV_SLEEP_PIN];
    assign linBSleepLvl = syncStage2_reg[LINB_SLEEP_PIN];
    assign linCSleepLvl = syncStage2_reg[LINC_SLEEP_PIN];

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] convCtrl_reg;
    logic [7:0] linBCtrl_reg;
    logic [7:0] linCCtrl_reg;

    wire logic       hitConv;
    wire logic       hitLinB;
    wire logic       hitLinC;
    wire logic [7:0] wrMasked;
    wire logic [7:0] rdNext;

    assign hitConv  = regReq.addr == rcr_pkg::CONV_F_OFFSET;
    assign hitLinB  = regReq.addr == rcr_pkg::LIN_B_OFFSET;
    assign hitLinC  = regReq.addr == rcr_pkg::LIN_C_OFFSET;
    // reserved values written by the host are stored as given; the
    // device does not repair them
    assign wrMasked = regReq.wrData & rcr_pkg::WRITE_MASK;
    assign rdNext   = hitConv ? convCtrl_reg :
                      hitLinB ? linBCtrl_reg :
                      hitLinC ? linCCtrl_reg :
                      rcr_pkg::UNMAPPED_RD;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            convCtrl_reg <= CONV_RESET;
            linBCtrl_reg <= LINB_RESET;
            linCCtrl_reg <= LINC_RESET;
        end
        else if (regReq.wrEn)
        begin
            convCtrl_reg <= hitConv ? wrMasked : convCtrl_reg;
            linBCtrl_reg <= hitLinB ? wrMasked : linBCtrl_reg;
            linCCtrl_reg <= hitLinC ? wrMasked : linCCtrl_reg;
        end
    end

    // read data is registered and held until the next read
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            regRdData <= rcr_pkg::UNMAPPED_RD;
        end
        else if (regReq.rdEn)
        begin
            regRdData <= rdNext;
        end
    end

    // ------------------------------------------------------------
    // rails
    // ------------------------------------------------------------
    rcr_rail
    #(
        .HAS_MODE (1'b1),
        .EN_MASK  (CONV_EN_MASK)
    )
    convRail
    (
        .clk        (core_clk),
        .rstN       (reset_n),
        .ctrl       (convCtrl_reg),
        .sleepLvl   (convSleepLvl),
        .enPins     (enPinsSync),
        .normalCode (convFVoltageCode),
        .sleepCode  (convFSleepVoltageCode),
        .railOut    (convFOut)
    );

    rcr_rail
    #(
        .HAS_MODE (1'b0),
        .EN_MASK  (LINB_EN_MASK)
    )
    linBRail
    (
        .clk        (core_clk),
        .rstN       (reset_n),
        .ctrl       (linBCtrl_reg),
        .sleepLvl   (linBSleepLvl),
        .enPins     (enPinsSync),
        .normalCode (linBVoltageCode),
        .sleepCode  (linBSleepVoltageCode),
        .railOut    (linBOut)
    );

    rcr_rail
    #(
        .HAS_MODE (1'b0),
        .EN_MASK  (LINC_EN_MASK)
    )
    linCRail
    (
        .clk        (core_clk),
        .rstN       (reset_n),
        .ctrl       (linCCtrl_reg),
        .sleepLvl   (linCSleepLvl),
        .enPins     (enPinsSync),
        .normalCode (linCVoltageCode),
        .sleepCode  (linCSleepVoltageCode),
        .railOut    (linCOut)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence sWriteConv;
        regReq.wrEn && regReq.addr == 8'h27;
    endsequence

    sequence sReadConv;
        regReq.rdEn && !regReq.wrEn && regReq.addr == 8'h27;
    endsequence

    sequence sWriteLinB;
        regReq.wrEn && regReq.addr == rcr_pkg::LIN_B_OFFSET;
    endsequence

    sequence sReadLinB;
        regReq.rdEn && !regReq.wrEn && regReq.addr == rcr_pkg::LIN_B_OFFSET;
    endsequence

    a_conv_rsvd_reset: assert property (@(posedge core_clk)
        $rose(reset_n) |-> convCtrl_reg[3:2] == 2'h3)
        else $error("converter reserved bits wrong after reset");
    a_lin_rsvd_reset: assert property (@(posedge core_clk)
        $rose(reset_n) |-> (linBCtrl_reg[3:1] == 3'h6
                             && linCCtrl_reg[3:1] == 3'h6))
        else $error("linear reserved bits wrong after reset");
    a_top_bits_zero: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        regRdData[7:6] == 2'h0 && convCtrl_reg[7:6] == 2'h0
        && linBCtrl_reg[7:6] == 2'h0 && linCCtrl_reg[7:6] == 2'h0)
        else $error("bits 7:6 not zero");
    a_write_readback: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        sWriteConv ##1 sReadConv
        |=> regRdData == {2'h0, $past(regReq.wrData[5:0], 2)})
        else $error("converter readback mismatch");
    a_linb_readback: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        sWriteLinB ##1 sReadLinB
        |=> regRdData == {2'h0, $past(regReq.wrData[5:0], 2)})
        else $error("linear b readback mismatch");

    // a write lands in the addressed register only, bits 7:6 dropped
    a_conv_write_lands: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        (regReq.wrEn && regReq.addr == rcr_pkg::CONV_F_OFFSET)
        |=> convCtrl_reg == {2'h0, $past(regReq.wrData[5:0])})
        else $error("converter write not stored");
    a_linb_write_lands: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        (regReq.wrEn && regReq.addr == rcr_pkg::LIN_B_OFFSET)
        |=> linBCtrl_reg == {2'h0, $past(regReq.wrData[5:0])})
        else $error("linear b write not stored");
    a_linc_write_lands: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        (regReq.wrEn && regReq.addr == rcr_pkg::LIN_C_OFFSET)
        |=> linCCtrl_reg == {2'h0, $past(regReq.wrData[5:0])})
        else $error("linear c write not stored");
    a_conv_write_kept: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        !(regReq.wrEn && regReq.addr == rcr_pkg::CONV_F_OFFSET)
        |=> $stable(convCtrl_reg))
        else $error("converter register changed without a write");
    a_linb_write_kept: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        !(regReq.wrEn && regReq.addr == rcr_pkg::LIN_B_OFFSET)
        |=> $stable(linBCtrl_reg))
        else $error("linear b register changed without a write");
    a_linc_write_kept: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        !(regReq.wrEn && regReq.addr == rcr_pkg::LIN_C_OFFSET)
        |=> $stable(linCCtrl_reg))
        else $error("linear c register changed without a write");

    // read data comes from the addressed register and then stands
    a_conv_read_data: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        (regReq.rdEn && regReq.addr == rcr_pkg::CONV_F_OFFSET)
        |=> regRdData == $past(convCtrl_reg))
        else $error("converter read data wrong");
    a_linb_read_data: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        (regReq.rdEn && regReq.addr == rcr_pkg::LIN_B_OFFSET)
        |=> regRdData == $past(linBCtrl_reg))
        else $error("linear b read data wrong");
    a_linc_read_data: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        (regReq.rdEn && regReq.addr == rcr_pkg::LIN_C_OFFSET)
        |=> regRdData == $past(linCCtrl_reg))
        else $error("linear c read data wrong");
    a_unmapped_read_zero: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        (regReq.rdEn && (regReq.addr < rcr_pkg::CONV_F_OFFSET
                         || regReq.addr > rcr_pkg::LIN_C_OFFSET))
        |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_read_data_holds: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        !regReq.rdEn |=> $stable(regRdData))
        else $error("read data changed without a read");

    // pins reach the rails through exactly two flip-flops; the sampled
    // reset keeps the release edge, which still clears them, out
    a_sync_two_stage: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        reset_n |-> ##2 syncStage2_reg == {$past(enableControlPins, 2),
            $past(sleepPinTwo_n, 2), $past(sleepPinOne_n, 2)})
        else $error("pin synchroniser latency wrong");

endmodule

`default_nettype wire

/* File: tb/rcr_host.sv */
// host model driving the register request port of the bank
`timescale 1ns/10ps
`default_nettype none

module rcr_host
(
    // clock
    input  wire logic                  core_clk,
    // register access
    output var  rcr_pkg::rcr_reg_req_t regReq,
    input  wire logic [7:0]            regRdData
);
    initial regReq = '0;

    // ---------------------------------------------------------------
    // bus cycles
    // ---------------------------------------------------------------
    // a well-behaved host only writes legal sleep and reserved fields
    function automatic logic [7:0] legal(input logic [7:0] a, d);
        legal = d;
        legal[4] = d[5];
        if (a == rcr_pkg::CONV_F_OFFSET)
            legal[3:2] = 2'h3;
        else
            legal[3:1] = 3'h6;
    endfunction

    // released lines carry the inverse so stale values cannot pass
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        regReq <= '{1'h1, 1'h0, a, legal(a, d)};
        @(posedge core_clk);
        regReq <= '{1'h0, 1'h0, ~a, ~legal(a, d)};
    endtask

    // write, then read the same register on the very next edge
    task automatic wrRd(input logic [7:0] a, d, output logic [7:0] q);
        @(posedge core_clk);
        regReq <= '{1'h1, 1'h0, a, legal(a, d)};
        @(posedge core_clk);
        regReq <= '{1'h0, 1'h1, a, 8'h5a};
        @(posedge core_clk);
        regReq <= '{1'h0, 1'h0, ~a, 8'ha5};
        @(posedge core_clk);
        #1 q = regRdData;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regReq <= '{1'h0, 1'h1, a, 8'h5a};
        @(posedge core_clk);
        regReq <= '{1'h0, 1'h0, ~a, 8'ha5};
        @(posedge core_clk);
        #1 d = regRdData;
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the rail control register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin \
    badCount++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module testbench;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;}
        rcr_row_t;
    localparam logic [7:0] BASE = rcr_pkg::CONV_F_OFFSET;
    localparam logic [5:0] MASK [3] = '{6'h01, 6'h06, 6'h38};
    localparam rcr_row_t   ROWS [8] = '{
        '{8'h27, 8'hff, 8'h3f}, '{8'h28, 8'h3d, 8'h3d},
        '{8'h29, 8'hfd, 8'h3d}, '{8'h27, 8'h0e, 8'h0e},
        '{8'h28, 8'h0c, 8'h0c}, '{8'h29, 8'h0c, 8'h0c},
        '{8'h27, 8'h1d, 8'h0d}, '{8'h2a, 8'h3d, 8'h00}};

    logic                   core_clk = 1'h0;
    logic                   reset_n  = 1'h0;
    rcr_pkg::rcr_reg_req_t  regReq;
    logic [7:0]             regRdData;
    logic                   slpOne_n = 1'h1;
    logic                   slpTwo_n = 1'h1;
    logic [5:0]             enPins   = 6'h00;
    logic [7:0]             codes [6];
    logic [7:0]             shadow [3];
    logic [7:0]             rdVal;
    rcr_pkg::rcr_rail_out_t convO;
    rcr_pkg::rcr_rail_out_t linBO;
    rcr_pkg::rcr_rail_out_t linCO;
    int                     badCount = 0;
    int                     cmpCount = 0;

    always #12.5 core_clk = ~core_clk;

    rcr_bank
    #(
        .LINB_SLEEP_PIN (rcr_pkg::SLEEP_PIN_TWO),
        .CONV_EN_MASK   (MASK[0]),
        .LINB_EN_MASK   (MASK[1]),
        .LINC_EN_MASK   (MASK[2])
    )
    u_dut
    (
        .core_clk              (core_clk),
        .reset_n               (reset_n),
        .regReq                (regReq),
        .regRdData             (regRdData),
        .sleepPinOne_n         (slpOne_n),
        .sleepPinTwo_n         (slpTwo_n),
        .enableControlPins     (enPins),
        .convFVoltageCode      (codes[0]),
        .convFSleepVoltageCode (codes[1]),
        .linBVoltageCode       (codes[2]),
        .linBSleepVoltageCode  (codes[3]),
        .linCVoltageCode       (codes[4]),
        .linCSleepVoltageCode  (codes[5]),
        .convFOut              (convO),
        .linBOut               (linBO),
        .linCOut               (linCO)
    );

    rcr_host u_host
    (
        .core_clk  (core_clk),
        .regReq    (regReq),
        .regRdData (regRdData)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic rcr_pkg::rcr_rail_out_t expOut(input int k);
        logic pin_n;
        pin_n = (k == 0) ? slpOne_n : slpTwo_n;
        expOut.code = (shadow[k][5:4] == 2'h3 && !pin_n) ?
            codes[2 * k + 1] : codes[2 * k];
        expOut.on = shadow[k][0] & |(enPins & MASK[k]);
        expOut.forcedPwm = (k == 0) & shadow[k][1];
    endfunction

    // pins pass two synchroniser stages, so allow four edges
    task automatic chkAll();
        repeat (4) @(posedge core_clk);
        #1;
        `CHK("convF", expOut(0), convO)
        `CHK("linB", expOut(1), linBO)
        `CHK("linC", expOut(2), linCO)
    endtask

    task automatic readAll();
        for (int k = 0; k < 3; k++)
        begin
            u_host.rd(8'(BASE + k), rdVal);
            `CHK("register", shadow[k], rdVal)
        end
    endtask

    task automatic wrS(input int k, input logic [7:0] d);
        u_host.wr(8'(BASE + k), d);
        shadow[k] = d;
    endtask

    task automatic doReset();
        @(posedge core_clk);
        reset_n <= 1'h0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'h1;
        shadow[0] = {2'h0, rcr_pkg::CONV_FACTORY_DEF[5:4], 2'h3,
                     rcr_pkg::CONV_FACTORY_DEF[1:0]};
        for (int k = 1; k < 3; k++)
            shadow[k] = {2'h0, rcr_pkg::LIN_FACTORY_DEF[5:4], 3'h6,
                         rcr_pkg::LIN_FACTORY_DEF[0]};
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk);
        badCount++;
        summarize();
    end

    initial
    begin
        for (int k = 0; k < 6; k++)
            codes[k] = 8'(8'h21 * k + 8'h10);
        doReset();
        readAll();
        foreach (ROWS[i])
        begin
            @(posedge core_clk);
            slpOne_n <= i[0];
            slpTwo_n <= i[1];
            enPins   <= 6'(i * 7);
            for (int k = 0; k < 6; k++)
                codes[k] <= 8'(codes[k] + 8'h13);
            u_host.wr(ROWS[i].a, ROWS[i].d);
            u_host.rd(ROWS[i].a, rdVal);
            `CHK("readback", ROWS[i].e, rdVal)
            if (ROWS[i].a >= BASE && ROWS[i].a <= 8'h29)
                shadow[ROWS[i].a - BASE] = ROWS[i].e;
            chkAll();
        end
        // back to back write and read of one register
        u_host.wrRd(BASE, 8'hf2, rdVal);
        `CHK("back to back", 8'h3e, rdVal)
        u_host.wrRd(8'h28, 8'h3d, rdVal);
        `CHK("back to back", 8'h3d, rdVal)
        shadow[0] = 8'h3e;
        shadow[1] = 8'h3d;
        readAll();
        // sleep fields active, each pin pair and enable pin in turn
        wrS(0, 8'h3f);
        wrS(1, 8'h3d);
        wrS(2, 8'h3d);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge core_clk);
            slpOne_n <= i[0];
            slpTwo_n <= i[1];
            enPins   <= 6'(1 << (i % 6));
            chkAll();
        end
        // disable bits win over every enable pin
        wrS(0, 8'h3e);
        wrS(1, 8'h3c);
        wrS(2, 8'h3c);
        @(posedge core_clk);
        enPins <= 6'h3f;
        chkAll();
        doReset();
        readAll();
        chkAll();
        summarize();
    end
endmodule
`default_nettype wire
